// File: tb/flag_branch_and_bit_clear_exec_bench.sv
// Self-checking bench of the flag branch and bit clear execution block
`timescale 1ns/1ps
`default_nettype none
module flag_branch_and_bit_clear_exec_bench;
  import fbbc_pkg::*;
  // Clock, reset and APB master signals
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  // Fetch side, flags and register file side
  logic [15:0] instrWord = 16'h0000;
  logic instrValid = 1'b0;
  logic [PC_W-1:0] pcNext = '0;
  logic carryFlag = 1'b0;
  logic negativeFlag = 1'b0;
  logic [7:0] regRdData, regWrData;
  logic [11:0] regAddr;
  logic [PC_W-1:0] pcWrData;
  logic instrAccept, pcWrEn, regRdEn, regWrEn, nopCycle, instrDone;
  // Counters and per-instruction observations
  int failCount = 0;
  int checkCount = 0;
  int span, pcWrs, regWrs, taken;
  logic nopSeen;
  logic [PC_W-1:0] pcGot, pcSet;
  logic [11:0] addrGot;
  logic [7:0] dataGot;
  logic [31:0] rd;
  logic er;

  flag_branch_and_bit_clear_exec #(.QDIV(1)) i_dut (
    .sys_clk, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .instrWord, .instrValid, .pcNext, .carryFlag, .negativeFlag, .regRdData, .instrAccept,
    .pcWrEn, .pcWrData, .regRdEn, .regAddr, .regWrEn, .regWrData, .nopCycle, .instrDone
  );
  reg_file_model i_mem (.sys_clk, .regRdEn, .regAddr, .regWrEn, .regWrData, .regRdData);

  // Free-running 125 MHz clock
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  // Verdict and end of run
  task automatic finalReport();
    $display("checks=%0d mismatches=%0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Value comparison
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      failCount++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  // One APB transfer, request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Offer one instruction, then record pulses until it finishes
  task automatic exec(input logic [15:0] w, input logic c, input logic ng);
    int k;
    k = 0;
    pcSet = PC_W'($urandom);
    instrWord <= w;
    pcNext <= pcSet;
    carryFlag <= c;
    negativeFlag <= ng;
    instrValid <= 1'b1;
    do begin
      @(posedge sys_clk);
      k++;
    end while (instrAccept !== 1'b1 && k < 20);
    instrValid <= 1'b0;
    span = 0;
    pcWrs = 0;
    regWrs = 0;
    nopSeen = 1'b0;
    while (instrDone !== 1'b1 && span < 20) begin
      @(posedge sys_clk);
      span++;
      if (pcWrEn === 1'b1) begin
        pcWrs++;
        pcGot = pcWrData;
      end
      if (regWrEn === 1'b1) begin
        regWrs++;
        addrGot = regAddr;
        dataGot = regWrData;
      end
      if (nopCycle === 1'b1) nopSeen = 1'b1;
    end
  endtask

  // Incremented PC plus twice the signed offset
  function automatic logic [PC_W-1:0] expTarget(input logic [PC_W-1:0] pc, input logic [7:0] n);
    return pc + PC_W'(2 * int'($signed(n)));
  endfunction

  // Operand address of the bit clear
  function automatic logic [11:0] expAddr(input logic a, input logic ext, input logic [7:0] f,
                                          input logic [3:0] bk, input logic [11:0] ix);
    if (a) return {bk, f};
    if (ext && f <= 8'h5F) return ix + {4'h0, f};
    return {(f[7] ? 4'hF : 4'h0), f};
  endfunction

  // Hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    failCount++;
    finalReport();
  end

  // Main sequence
  initial begin
    logic [7:0] op, off, f, old;
    logic [2:0] b;
    logic [3:0] bk;
    logic [11:0] ix, ea;
    logic a, ext, c, ng, tk;
    void'($urandom(45867));
    taken = 0;
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    // Reset values, then an unmapped place that must be refused
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0, rd, er);
      cmp(rd, (i == 0) ? 32'h2 : 32'h0);
      cmp(32'(er), 32'(i == 5));
    end
    apb(1'b1, 12'h010, 32'hFFFF, rd, er);
    // Relative branches over every opcode, both flag values and offset extremes
    for (int i = 0; i < 24; i++) begin
      op = (i % 3 == 0) ? 8'hE2 : ((i % 3 == 1) ? 8'hE3 : 8'hE6);
      off = (i < 3) ? 8'h80 : ((i < 6) ? 8'h7F : 8'($urandom));
      c = 1'($urandom);
      ng = 1'($urandom);
      exec({op, off}, c, ng);
      tk = (op == 8'hE2) ? c : ((op == 8'hE3) ? !c : ng);
      taken += tk;
      cmp(32'(pcWrs), 32'(tk));
      cmp(32'(span), tk ? 32'd7 : 32'd3);
      cmp(32'(nopSeen), 32'(tk));
      if (tk) cmp(32'(pcGot), 32'(expTarget(pcSet, off)));
    end
    apb(1'b0, 12'h010, 32'h0, rd, er);
    cmp(rd, 32'(taken));
    // Status shows the last class retired and nothing in flight
    apb(1'b0, 12'h00C, 32'h0, rd, er);
    cmp(rd, {27'h0, 3'(K_NEG_SET), 2'b00});
    // Bit clears over banked, access and indexed addressing
    for (int i = 0; i < 16; i++) begin
      a = 1'($urandom);
      ext = 1'($urandom);
      b = 3'($urandom);
      bk = 4'($urandom);
      ix = 12'($urandom);
      f = 8'($urandom);
      if (i < 4) begin
        a = 1'b0;
        ext = (i < 2);
        f = (i == 2) ? 8'h80 : (i[0] ? 8'h60 : 8'h5F);
      end
      apb(1'b1, 12'h000, {30'h0, 1'b1, ext}, rd, er);
      apb(1'b1, 12'h004, {28'h0, bk}, rd, er);
      apb(1'b1, 12'h008, {20'h0, ix}, rd, er);
      apb(1'b0, 12'h004, 32'h0, rd, er);
      cmp(rd, {28'h0, bk});
      ea = expAddr(a, ext, f, bk, ix);
      old = i_mem.mem[ea];
      exec({4'h9, b, a, f}, 1'b1, 1'b1);
      cmp(32'(addrGot), 32'(ea));
      cmp(32'(dataGot), 32'(old & ~(8'h01 << b)));
      cmp(32'(regWrs), 32'h1);
      cmp(32'(span), 32'd3);
    end
    // Run disabled: an offered instruction is never taken
    apb(1'b1, 12'h000, 32'h0, rd, er);
    instrWord <= 16'hE200;
    instrValid <= 1'b1;
    span = 0;
    repeat (12) begin
      @(posedge sys_clk);
      if (instrAccept === 1'b1) span++;
    end
    instrValid <= 1'b0;
    cmp(32'(span), 32'h0);
    // Unknown opcode is taken but does nothing
    apb(1'b1, 12'h000, 32'h2, rd, er);
    exec(16'h1234, 1'b1, 1'b1);
    cmp(32'(span), 32'd20);
    cmp(32'(pcWrs + regWrs), 32'h0);
    // Reset in the middle of a taken branch clears the idle cycle and the count and returns control to its reset value
    apb(1'b1, 12'h000, 32'h3, rd, er);
    instrWord <= 16'hE205;
    carryFlag <= 1'b1;
    instrValid <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pcWrEn !== 1'b1);
    instrValid <= 1'b0;
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    cmp(32'(nopCycle), 32'h0);
    apb(1'b0, 12'h000, 32'h0, rd, er);
    cmp(rd, 32'h2);
    apb(1'b0, 12'h010, 32'h0, rd, er);
    cmp(rd, 32'h0);
    finalReport();
  end
endmodule
`default_nettype wire

// File: tb/reg_file_model.sv
// Behavioural data register file on the far side of the execution block
`timescale 1ns/1ps
`default_nettype none
module reg_file_model (
  input wire logic sys_clk,
  input wire logic regRdEn,
  input wire logic [11:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData
);
  // Register storage, preset to an address pattern
  logic [7:0] mem [0:4095];
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = i[7:0] ^ 8'hC7;
    end
  end
  // Data is valid only while the read strobe is up; inverted otherwise to expose late reads
  assign regRdData = regRdEn ? mem[regAddr] : ~mem[regAddr];
  // Write back on the write strobe
  always @(posedge sys_clk) begin
    if (regWrEn) begin
      mem[regAddr] <= regWrData;
    end
  end
endmodule
`default_nettype wire

// File: verilog/fbbc_apb_regs.sv
// APB control and status registers of the execution block
`timescale 1ns/1ps
`default_nettype none
`include "fbbc_params.svh"
module fbbc_apb_regs
  import fbbc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic busy,
  input wire logic nopActive,
  input wire kind_t lastKind,
  input wire logic [15:0] takenCnt,
  output logic extEn,
  output logic runEn,
  output logic [3:0] bank,
  output logic [11:0] index
);

  apb_state_t st_q; // Registered state
  apb_state_t st_d; // Next state
  logic mapped; // Address hits a register

  // Decode in setup, answer in the first access cycle
  always_comb begin
    st_d = st_q;
    st_d.pready = 1'b0;
    mapped = (paddr == `FBBC_REG_CTRL) || (paddr == `FBBC_REG_BANK) ||
             (paddr == `FBBC_REG_INDEX) || (paddr == `FBBC_REG_STATUS) ||
             (paddr == `FBBC_REG_COUNT);
    if (psel && !penable) begin
      // Setup phase: prepare read data and error
      st_d.pready = 1'b1;
      st_d.pslverr = !mapped;
      st_d.prdata = 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          `FBBC_REG_CTRL: st_d.prdata = {30'h0, st_q.ctrl};
          `FBBC_REG_BANK: st_d.prdata = {28'h0, st_q.bank};
          `FBBC_REG_INDEX: st_d.prdata = {20'h0, st_q.index};
          `FBBC_REG_STATUS: st_d.prdata = {27'h0, lastKind, nopActive, busy};
          `FBBC_REG_COUNT: st_d.prdata = {16'h0, takenCnt};
          default: st_d.prdata = 32'h0000_0000;
        endcase
      end
    end else if (psel && penable && st_q.pready && pwrite && !st_q.pslverr) begin
      // Access edge: commit write
      if (paddr == `FBBC_REG_CTRL) begin
        st_d.ctrl = pwdata[1:0];
      end else if (paddr == `FBBC_REG_BANK) begin
        st_d.bank = pwdata[3:0];
      end else if (paddr == `FBBC_REG_INDEX) begin
        st_d.index = pwdata[11:0];
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= '0;
      st_q.ctrl <= `FBBC_CTRL_RESET;
      st_q.bank <= `FBBC_BANK_RESET;
      st_q.index <= `FBBC_INDEX_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign extEn = st_q.ctrl[`FBBC_CTRL_EXT_BIT];
  assign runEn = st_q.ctrl[`FBBC_CTRL_RUN_BIT];
  assign bank = st_q.bank;
  assign index = st_q.index;

endmodule
`default_nettype wire

// File: verilog/fbbc_params.svh
// Constants for the flag branch and bit clear execution block
`ifndef FBBC_PARAMS_SVH
`define FBBC_PARAMS_SVH

// Upper opcode bytes of the relative branches
`define FBBC_OP_CARRY_SET 8'hE2
`define FBBC_OP_CARRY_CLR 8'hE3
`define FBBC_OP_NEG_SET 8'hE6
// Leading nibble of the single bit clear
`define FBBC_OP_BIT_CLR 4'h9

// Access bank split point and high bank number
`define FBBC_ACCESS_SPLIT 8'h80
`define FBBC_ACCESS_HI_BANK 4'hF
`define FBBC_ACCESS_LO_BANK 4'h0
// Highest register address that uses indexed literal offset mode
`define FBBC_INDEXED_LIMIT 8'h5F

// Register byte offsets on the APB
`define FBBC_REG_CTRL 12'h000
`define FBBC_REG_BANK 12'h004
`define FBBC_REG_INDEX 12'h008
`define FBBC_REG_STATUS 12'h00C
`define FBBC_REG_COUNT 12'h010

// Control field positions
`define FBBC_CTRL_EXT_BIT 0
`define FBBC_CTRL_RUN_BIT 1

// Reset values
`define FBBC_CTRL_RESET 2'h2
`define FBBC_BANK_RESET 4'h0
`define FBBC_INDEX_RESET 12'h000

// System clock cycles per quarter phase
`define FBBC_QDIV 1

`endif

// File: verilog/fbbc_pkg.sv
// Types and decode helpers for the flag branch and bit clear execution block
`include "fbbc_params.svh"
package fbbc_pkg;

  // Program counter width
  localparam int PC_W = 21;

  // Quarter phases, Gray coded along Q1..Q4
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b11,
    PH_Q4 = 2'b10
  } qph_t;

  // Instruction classes handled here
  typedef enum logic [2:0] {
    K_NONE = 3'h0,
    K_CARRY_SET = 3'h1,
    K_CARRY_CLR = 3'h2,
    K_NEG_SET = 3'h3,
    K_BIT_CLR = 3'h4
  } kind_t;

  // Execution state of the main module
  typedef struct packed {
    qph_t ph;
    logic nop;
    kind_t kind;
    logic [15:0] instr;
    logic [PC_W-1:0] pc;
    logic taken;
    logic [7:0] rd;
    logic rdDone;
    logic accept;
    logic pcWrEn;
    logic [PC_W-1:0] pcWrData;
    logic regRdEn;
    logic [11:0] regAddr;
    logic regWrEn;
    logic [7:0] wdata;
    logic done;
    kind_t lastKind;
    logic [15:0] takenCnt;
  } exec_state_t;

  // Quarter strobe divider state
  typedef struct packed {
    logic [15:0] cnt;
    logic stb;
  } qdiv_state_t;

  // APB register slave state
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] ctrl;
    logic [3:0] bank;
    logic [11:0] index;
  } apb_state_t;

  // Classify an instruction word
  function automatic kind_t decode_kind(input logic [15:0] w);
    if (w[15:8] == `FBBC_OP_CARRY_SET) begin
      return K_CARRY_SET;
    end else if (w[15:8] == `FBBC_OP_CARRY_CLR) begin
      return K_CARRY_CLR;
    end else if (w[15:8] == `FBBC_OP_NEG_SET) begin
      return K_NEG_SET;
    end else if (w[15:12] == `FBBC_OP_BIT_CLR) begin
      return K_BIT_CLR;
    end
    return K_NONE;
  endfunction

  // Incremented PC plus twice the signed 8-bit offset
  function automatic logic [PC_W-1:0] branch_target(input logic [PC_W-1:0] pc,
                                                    input logic [7:0] off);
    return pc + {{(PC_W-9){off[7]}}, off, 1'b0};
  endfunction

  // Data address of the bit clear operand
  function automatic logic [11:0] clr_address(input logic [7:0] f, input logic a,
                                              input logic ext, input logic [3:0] bank,
                                              input logic [11:0] index);
    if (a) begin
      return {bank, f};
    end else if (ext && (f <= `FBBC_INDEXED_LIMIT)) begin
      return index + {4'h0, f};
    end else if (f >= `FBBC_ACCESS_SPLIT) begin
      return {`FBBC_ACCESS_HI_BANK, f};
    end
    return {`FBBC_ACCESS_LO_BANK, f};
  endfunction

endpackage

// File: verilog/flag_branch_and_bit_clear_exec.sv
// Decode and execute of carry and negative branches and the single bit clear
//
// Summary of operation
// RL1: Opcode E2h branches when carry is one
// RL2: Target is incremented PC plus twice offset
// RL3: Taken branch adds a no-operation cycle
// RL4: Opcode E6h branches when negative is one
// RL5: Opcode E3h branches when carry is zero
// RL6: Nibble 9h clears bit b of register
// RL7: Selector zero access bank, one banked
// RL8: Extended set, selector zero, f<=5Fh: indexed
// RL9: Read in Q2, write in Q4, no flags
`timescale 1ns/1ps
`default_nettype none
`include "fbbc_params.svh"
module flag_branch_and_bit_clear_exec
  import fbbc_pkg::*;
#(
  parameter int QDIV = `FBBC_QDIV
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] instrWord,
  input wire logic instrValid,
  input wire logic [PC_W-1:0] pcNext,
  input wire logic carryFlag,
  input wire logic negativeFlag,
  input wire logic [7:0] regRdData,
  output logic instrAccept,
  output logic pcWrEn,
  output logic [PC_W-1:0] pcWrData,
  output logic regRdEn,
  output logic [11:0] regAddr,
  output logic regWrEn,
  output logic [7:0] regWrData,
  output logic nopCycle,
  output logic instrDone
);

  // Local signals between the divider, the registers and the sequencer
  logic qStb; // One pulse per quarter phase
  logic extEn; // Extended instruction set enabled
  logic runEn; // Execution enabled
  logic [3:0] bank; // Bank select register
  logic [11:0] index; // Base of indexed literal offset mode
  exec_state_t st_q; // Registered state
  exec_state_t st_d; // Next state

  // Quarter phase strobe source
  // QDIV system clocks make one quarter; a QDIV of one runs a quarter a cycle
  qphase_strobe #(
    .QDIV(QDIV)
  ) u_qphase (
    .sys_clk(sys_clk),
    .srst(srst),
    .qStb(qStb)
  );

  // Software visible control and status
  // Status shows live state; control changes apply at the next quarter that reads them
  fbbc_apb_regs u_regs (
    .sys_clk(sys_clk),
    .srst(srst),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .busy(st_q.kind != K_NONE),
    .nopActive(st_q.nop),
    .lastKind(st_q.lastKind),
    .takenCnt(st_q.takenCnt),
    .extEn(extEn),
    .runEn(runEn),
    .bank(bank),
    .index(index)
  );

  // Quarter phase sequencer and instruction execution
  always_comb begin
    st_d = st_q;
    // Held fields keep their value unless a quarter updates them
    // Pulses last one cycle
    st_d.accept = 1'b0;
    st_d.pcWrEn = 1'b0;
    st_d.regRdEn = 1'b0;
    st_d.regWrEn = 1'b0;
    st_d.done = 1'b0;
    // Nothing moves between quarter strobes; held outputs keep their values and pulse outputs drop to zero
    if (qStb) begin
      unique case (st_q.ph)
        PH_Q1: begin
          st_d.ph = PH_Q2;
          // Decode; a no-operation cycle takes nothing
          // Word and PC are latched so later fetches cannot disturb them
          if (!st_q.nop && instrValid && runEn) begin
            st_d.instr = instrWord;
            st_d.pc = pcNext;
            st_d.kind = decode_kind(instrWord); // RL1 RL4 RL5 RL6
            st_d.accept = 1'b1;
            st_d.rdDone = 1'b0;
            st_d.taken = 1'b0;
          end
        end
        PH_Q2: begin
          st_d.ph = PH_Q3;
          // Bit clear reads its operand now
          // Bank, index and mode are read here; later writes do not apply
          if (st_q.kind == K_BIT_CLR) begin
            st_d.regRdEn = 1'b1; // RL9
            st_d.rdDone = 1'b1;
            st_d.regAddr = clr_address(st_q.instr[7:0], st_q.instr[8], extEn, bank,
                                       index); // RL7 RL8
          end
        end
        PH_Q3: begin
          st_d.ph = PH_Q4;
          // Process data: evaluate condition or capture operand
          // Flags are sampled late so a producer earlier in the cycle is seen
          unique case (st_q.kind)
            K_CARRY_SET: st_d.taken = carryFlag; // RL1
            K_CARRY_CLR: st_d.taken = !carryFlag; // RL5
            K_NEG_SET: st_d.taken = negativeFlag; // RL4
            K_BIT_CLR: st_d.rd = regRdData;
            K_NONE: st_d.taken = 1'b0;
            default: st_d.taken = 1'b0;
          endcase
        end
        PH_Q4: begin
          st_d.ph = PH_Q1;
          // Q4 writes results; the idle cycle writes nothing
          if (st_q.nop) begin
            // End of the inserted no-operation cycle
            st_d.nop = 1'b0;
            st_d.done = 1'b1;
          end else if (st_q.kind == K_BIT_CLR) begin
            // Write back with only the chosen bit cleared
            st_d.regWrEn = 1'b1; // RL9
            st_d.wdata = st_q.rd & ~(8'h01 << st_q.instr[11:9]); // RL6
            st_d.done = 1'b1;
          end else if (st_q.kind != K_NONE) begin
            if (st_q.taken) begin
              // Taken: write PC, then spend one idle cycle
              st_d.pcWrEn = 1'b1;
              st_d.pcWrData = branch_target(st_q.pc, st_q.instr[7:0]); // RL2
              st_d.nop = 1'b1; // RL3
              // Count taken branches for software
              st_d.takenCnt = st_q.takenCnt + 16'h0001;
            end else begin
              // Not taken: last quarter only signals completion
              st_d.done = 1'b1; // RL3
            end
          end
          // Remember the class for status, then retire
          if (st_q.kind != K_NONE) begin
            st_d.lastKind = st_q.kind;
          end
          st_d.kind = K_NONE;
        end
        default: st_d.ph = PH_Q1;
      endcase
    end
  end

  // State register
  // Synchronous reset returns to Q1 with nothing in flight
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register; no status flag is driven
  // Each output is a register bit, so the far side sees no decode glitches
  assign instrAccept = st_q.accept;
  assign pcWrEn = st_q.pcWrEn;
  assign pcWrData = st_q.pcWrData;
  assign regRdEn = st_q.regRdEn;
  assign regAddr = st_q.regAddr;
  assign regWrEn = st_q.regWrEn;
  assign regWrData = st_q.wdata; // RL9
  assign nopCycle = st_q.nop;
  assign instrDone = st_q.done;

  // Carry set condition follows the carry sampled in Q3
  carry_set_a: assert property ( // RL1
    @(posedge sys_clk) disable iff (srst)
    (qStb && st_q.ph == PH_Q3 && st_q.kind == K_CARRY_SET)
      |=> (st_q.taken == $past(carryFlag)))
    else $error("carry set condition wrong");

  // Target equals latched PC plus doubled signed offset
  branch_target_a: assert property ( // RL2
    @(posedge sys_clk) disable iff (srst)
    $rose(pcWrEn) |-> (pcWrData == $past(st_q.pc) +
      {{(PC_W-9){$past(st_q.instr[7])}}, $past(st_q.instr[7:0]), 1'b0}))
    else $error("branch target wrong");

  // A PC write is followed by a whole idle cycle with no accept
  taken_nop_a: assert property ( // RL3
    @(posedge sys_clk) disable iff (srst)
    pcWrEn |-> nopCycle ##1 (!instrAccept && nopCycle) [*3])
    else $error("taken branch lacks idle cycle");

  // Untaken branch never writes the PC
  untaken_quiet_a: assert property ( // RL3
    @(posedge sys_clk) disable iff (srst)
    (qStb && st_q.ph == PH_Q4 && !st_q.nop && !st_q.taken)
      |=> !pcWrEn)
    else $error("untaken branch wrote PC");

  // Negative condition follows the flag sampled in Q3
  neg_set_a: assert property ( // RL4
    @(posedge sys_clk) disable iff (srst)
    (qStb && st_q.ph == PH_Q3 && st_q.kind == K_NEG_SET)
      |=> (st_q.taken == $past(negativeFlag)))
    else $error("negative condition wrong");

  // Carry clear condition is the inverse of carry
  carry_clr_a: assert property ( // RL5
    @(posedge sys_clk) disable iff (srst)
    (qStb && st_q.ph == PH_Q3 && st_q.kind == K_CARRY_CLR)
      |=> (st_q.taken != $past(carryFlag)))
    else $error("carry clear condition wrong");

  // Written byte equals read byte with one bit cleared
  bit_clear_a: assert property ( // RL6
    @(posedge sys_clk) disable iff (srst)
    regWrEn |-> (regWrData[$past(st_q.instr[11:9])] == 1'b0) &&
      ((regWrData | (8'h01 << $past(st_q.instr[11:9]))) ==
       ($past(st_q.rd) | (8'h01 << $past(st_q.instr[11:9])))))
    else $error("bit clear data wrong");

  // Banked operand uses the bank select register
  banked_addr_a: assert property ( // RL7
    @(posedge sys_clk) disable iff (srst)
    (regRdEn && st_q.instr[8]) |-> (regAddr == {$past(bank), st_q.instr[7:0]}))
    else $error("banked address wrong");

  // Access bank operand without extended mode
  access_addr_a: assert property ( // RL7
    @(posedge sys_clk) disable iff (srst)
    (regRdEn && !st_q.instr[8] && !$past(extEn)) |->
      (regAddr[7:0] == st_q.instr[7:0]) &&
      (regAddr[11:8] == (st_q.instr[7] ? 4'hF : 4'h0)))
    else $error("access bank address wrong");

  // Indexed literal offset mode in extended set
  indexed_addr_a: assert property ( // RL8
    @(posedge sys_clk) disable iff (srst)
    (regRdEn && !st_q.instr[8] && $past(extEn) && st_q.instr[7:0] <= 8'h5F) |->
      (regAddr == $past(index) + {4'h0, st_q.instr[7:0]}))
    else $error("indexed address wrong");

  // Write back only after this instruction's own read
  rmw_order_a: assert property ( // RL9
    @(posedge sys_clk) disable iff (srst)
    regWrEn |-> st_q.rdDone && !pcWrEn && instrDone)
    else $error("write without prior read");

  // Sequencing checks: instruction intake, idle cycle, PC write source, single read
  accept_gate_a: assert property ( // RL3
    @(posedge sys_clk) disable iff (srst)
    instrAccept |-> ($past(runEn) && !$past(nopCycle)))
    else $error("instruction taken while stopped or idle");

  // The idle cycle ends together with the completion pulse
  nop_end_a: assert property ( // RL3
    @(posedge sys_clk) disable iff (srst)
    $fell(nopCycle) |-> instrDone)
    else $error("idle cycle ended without completion");

  // A PC write comes only from a taken branch outside an idle cycle
  pc_source_a: assert property ( // RL3
    @(posedge sys_clk) disable iff (srst)
    pcWrEn |-> ($past(st_q.taken) && !$past(nopCycle) && !regWrEn && !regRdEn))
    else $error("PC written without a taken branch");

  // The operand is read once, never merged with its write
  read_once_a: assert property ( // RL9
    @(posedge sys_clk) disable iff (srst)
    regRdEn |=> (!regRdEn && !regWrEn))
    else $error("operand read repeated or merged with write");

  // A register write never falls into an idle cycle
  write_not_idle_a: assert property ( // RL9
    @(posedge sys_clk) disable iff (srst)
    regWrEn |-> (!nopCycle && !$past(nopCycle)))
    else $error("register written during idle cycle");

endmodule
`default_nettype wire

// File: verilog/qphase_strobe.sv
// Quarter phase strobe divider
`timescale 1ns/1ps
`default_nettype none
`include "fbbc_params.svh"
module qphase_strobe
  import fbbc_pkg::*;
#(
  parameter int QDIV = `FBBC_QDIV
) (
  input wire logic sys_clk,
  input wire logic srst,
  output logic qStb
);

  // Divider must fit the counter; refused at elaboration
  if (QDIV < 1 || QDIV > 65535) begin : g_qdiv_check
    $error("QDIV out of range");
  end

  qdiv_state_t st_q; // Registered state
  qdiv_state_t st_d; // Next state

  // Count down and pulse once per quarter
  always_comb begin
    st_d = st_q;
    st_d.stb = 1'b0;
    if (st_q.cnt == 16'h0000) begin
      st_d.cnt = 16'(QDIV - 1);
      st_d.stb = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt - 16'h0001;
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign qStb = st_q.stb;

endmodule
`default_nettype wire
